// [dfcr_top.sv]
// Per-component spatial dither followed by frame rate modulation to one bit.
`timescale 1ns/1ps
`default_nettype none

module dfcr_top (
  // Clock and reset
  input  wire logic                      ref_clk_in,
  input  wire logic                      rst_b_in,
  // Pixel stream
  input  wire logic                      pix_valid_in,
  input  wire dfcr_pkg::dfcr_rgb_type    pix_rgb_in,
  input  wire logic                      line_done_in,
  input  wire logic                      frame_start_in,
  // Pseudo-random offsets, low six bits per component
  input  wire dfcr_pkg::dfcr_rand_type   rand_pixel_in,
  input  wire dfcr_pkg::dfcr_rand_type   rand_line_in,
  // Control
  input  wire logic                      mode_modified_in,
  // Pattern and sequence memory load port
  input  wire dfcr_pkg::dfcr_memwr_type  mem_wr_in,
  // Panel side
  output logic                           panel_valid_out,
  output logic [dfcr_pkg::NUM_COMP-1:0]  panel_bits_out
);

  // ---------------------------------------------------------------------------
  // Configuration checks
  // ---------------------------------------------------------------------------
  // The slices below are written for a six-bit intensity and a four by four tile,
  // so a package edit that changes either must stop elaboration here.
  if (dfcr_pkg::INT_W != 6) begin : g_bad_int_w
    $error("Intensity width must be six bits");
  end
  if (dfcr_pkg::SEL_W != dfcr_pkg::INT_W - 1) begin : g_bad_sel_w
    $error("Sequence selector must be the intensity without its lowest bit");
  end
  if (dfcr_pkg::PHASE_W != 2) begin : g_bad_phase_w
    $error("Tile phases must be two bits wide");
  end
  if (dfcr_pkg::FRAME_W != 6) begin : g_bad_frame_w
    $error("Frame index must span one sixty-four frame sequence");
  end
  if (dfcr_pkg::FRM_ADDR_W != dfcr_pkg::FRAME_W + dfcr_pkg::SEL_W) begin : g_bad_frm_addr
    $error("Sequence address must be frame index over selector");
  end
  if (dfcr_pkg::DTH_ADDR_W != 2 * dfcr_pkg::PHASE_W + 4) begin : g_bad_dth_addr
    $error("Tile address must be two phases over four intensity bits");
  end
  if (dfcr_pkg::DTH_ADDR_W > dfcr_pkg::FRM_ADDR_W) begin : g_bad_load_addr
    $error("Load port address is too narrow for the tile memory");
  end
  if (dfcr_pkg::NUM_COMP != 3) begin : g_bad_num_comp
    $error("Exactly three colour components are carried");
  end
  if (dfcr_pkg::COMP_ALL != 2'h0) begin : g_bad_comp_all
    $error("Broadcast load code collides with a component code");
  end
  if (dfcr_pkg::COARSE_MAX != (dfcr_pkg::SEL_MAX >> 1)) begin : g_bad_coarse_max
    $error("Coarse and fine saturation limits disagree");
  end

  // ---------------------------------------------------------------------------
  // Screen position and frame index
  // ---------------------------------------------------------------------------
  logic [dfcr_pkg::PHASE_W-1:0] x_q;
  logic [dfcr_pkg::PHASE_W-1:0] x_d;
  logic [dfcr_pkg::PHASE_W-1:0] y_q;
  logic [dfcr_pkg::PHASE_W-1:0] y_d;
  logic [dfcr_pkg::FRAME_W-1:0] frame_index_q;
  logic [dfcr_pkg::FRAME_W-1:0] frame_index_d;

  // A frame start wins over a line end so that each screen opens at phase 00.
  // Both phases wrap modulo four by their width, which walks the tile.
  assign x_d = frame_start_in ? dfcr_pkg::PHASE_RST :
               line_done_in   ? dfcr_pkg::PHASE_RST :
               pix_valid_in   ? x_q + 2'h1 : x_q;
  assign y_d = frame_start_in ? dfcr_pkg::PHASE_RST :
               line_done_in   ? y_q + 2'h1 : y_q;
  // The frame index wraps at 64 by its width, matching the sequence length.
  assign frame_index_d = frame_start_in ? frame_index_q + 6'h01 : frame_index_q;

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      x_q           <= dfcr_pkg::PHASE_RST;
      y_q           <= dfcr_pkg::PHASE_RST;
      frame_index_q <= dfcr_pkg::FRAME_RST;
    end else begin
      x_q           <= x_d;
      y_q           <= y_d;
      frame_index_q <= frame_index_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Component slices
  // ---------------------------------------------------------------------------
  logic [dfcr_pkg::INT_W-1:0]   comp_int  [dfcr_pkg::NUM_COMP];
  logic [dfcr_pkg::FRAME_W-1:0] comp_rpix [dfcr_pkg::NUM_COMP];
  logic [dfcr_pkg::FRAME_W-1:0] comp_rlin [dfcr_pkg::NUM_COMP];
  logic [dfcr_pkg::NUM_COMP-1:0] comp_bit;

  // Index 0 is red, 1 green, 2 blue; matches the load port codes 1..3.
  assign comp_int[0]  = pix_rgb_in.red;
  assign comp_int[1]  = pix_rgb_in.green;
  assign comp_int[2]  = pix_rgb_in.blue;
  assign comp_rpix[0] = rand_pixel_in.red;
  assign comp_rpix[1] = rand_pixel_in.green;
  assign comp_rpix[2] = rand_pixel_in.blue;
  assign comp_rlin[0] = rand_line_in.red;
  assign comp_rlin[1] = rand_line_in.green;
  assign comp_rlin[2] = rand_line_in.blue;

  // ---------------------------------------------------------------------------
  // Per-component dither, modulation and storage
  // ---------------------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < dfcr_pkg::NUM_COMP; c = c + 1) begin : g_comp
      logic [dfcr_pkg::FRM_DEPTH-1:0]  frm_mem_q;
      logic [dfcr_pkg::DTH_DEPTH-1:0]  dth_mem_q;
      logic [dfcr_pkg::DTH_ADDR_W-1:0] dth_addr;
      logic [dfcr_pkg::FRM_ADDR_W-1:0] frm_addr;
      logic [dfcr_pkg::FRAME_W-1:0]    frame_ofs;
      logic [3:0]                      coarse;
      logic                            extreme;
      logic                            use_coarse;
      logic                            mem_bit;
      logic                            hw_bit;
      logic                            pat_bit;
      logic [dfcr_pkg::SEL_W-1:0]      fine_sum;
      logic [3:0]                      coarse_sum;
      logic [dfcr_pkg::SEL_W-1:0]      dithered;
      logic                            sel_here;
      logic                            wr_frm;
      logic                            wr_dth;
      logic                            fine_top;
      logic                            coarse_top;
      logic [dfcr_pkg::SEL_W-1:0]      fine_base;
      logic [dfcr_pkg::DTH_ADDR_W-1:0] dth_wr_addr;

      // The programmable tile encodes whichever fill order the table writer
      // chose, so every N-bit scheme except the fixed 1-bit pattern of modified mode shares one lookup.
      assign dth_addr = {x_q, y_q, comp_int[c][3:0]};
      assign mem_bit  = dth_mem_q[dth_addr];

      // Fixed checkerboard: alternating zeros and ones across the tile when intensity bit 0 is set, all zeros otherwise.
      assign hw_bit   = comp_int[c][0] & (x_q[0] ^ y_q[0]);

      assign coarse     = comp_int[c][5:2];
      assign extreme    = (coarse == dfcr_pkg::COARSE_MAX) ||
                          (coarse == dfcr_pkg::COARSE_ZERO);
      assign use_coarse = (mode_modified_in == dfcr_pkg::MODE_MODIFIED) && extreme;

      // In modified mode the middle range ignores the tile memory and takes the fixed pattern.
      assign pat_bit = (mode_modified_in == dfcr_pkg::MODE_NORMAL) ? mem_bit :
                       extreme ? mem_bit : hw_bit;

      // Adding one step never wraps: full scale stays at full scale.
      assign fine_base  = comp_int[c][5:1];
      assign fine_top   = (fine_base == dfcr_pkg::SEL_MAX);
      assign coarse_top = (coarse == dfcr_pkg::COARSE_MAX);
      assign fine_sum   = fine_top ? dfcr_pkg::SEL_MAX : fine_base + {4'h0, pat_bit};
      assign coarse_sum = coarse_top ? dfcr_pkg::COARSE_MAX : coarse + {3'h0, pat_bit};

      // The coarse result keeps its low selector bit at zero; the sequence table
      // holds duplicated pairs there.
      assign dithered = use_coarse ? {coarse_sum, 1'b0} : fine_sum;

      // The offset sum wraps modulo 64, so every pixel stays on a circular sequence.
      assign frame_ofs = frame_index_q + comp_rpix[c] + comp_rlin[c];
      assign frm_addr  = {frame_ofs, dithered};
      assign comp_bit[c] = frm_mem_q[frm_addr];

      // A write lands on the next edge, so loading while pixels flow can show a
      // mixed table for one frame; tables are meant to be loaded before display.
      assign sel_here = (mem_wr_in.comp == dfcr_pkg::COMP_ALL) ||
                        (mem_wr_in.comp == 2'(c + 1));
      assign wr_frm   = mem_wr_in.wr && sel_here && !mem_wr_in.to_dither;
      assign wr_dth   = mem_wr_in.wr && sel_here && mem_wr_in.to_dither;

      // The load port carries a sequence-sized address; a tile write uses its low bits.
      assign dth_wr_addr = mem_wr_in.addr[dfcr_pkg::DTH_ADDR_W-1:0];

      always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          frm_mem_q <= '0;
        end else if (wr_frm) begin
          frm_mem_q[mem_wr_in.addr] <= mem_wr_in.data;
        end
      end

      always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          dth_mem_q <= '0;
        end else if (wr_dth) begin
          dth_mem_q[dth_wr_addr] <= mem_wr_in.data;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Panel output register
  // ---------------------------------------------------------------------------
  logic [dfcr_pkg::NUM_COMP-1:0] bits_d;

  // Bits hold their last value between pixels so the panel sees no glitches.
  assign bits_d = pix_valid_in ? comp_bit : panel_bits_out;

  // The strobe is a plain copy of the pixel qualifier: latency is one edge.

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      panel_valid_out <= 1'b0;
      panel_bits_out  <= '0;
    end else begin
      panel_valid_out <= pix_valid_in;
      panel_bits_out  <= bits_d;
    end
  end

endmodule

`default_nettype wire

// [dfcr_pkg.sv]
// Constants and carrier types of the dither and FRM colour reduction path.
// Summary of operation
// - Dither over 4x4 tile, low bits pick pattern
// - Pattern 0 passes truncated, 1 adds step
// - Two-bit X and Y phases, reset per screen
// - 4-bit scheme: N ones, zero gives none
// - 3-bit scheme: two ones per increment
// - 2-bit scheme: four ones per increment
// - 1-bit scheme: zero or alternating tile
// - Dither first, then feed modulation
// - Modulation selected by upper five intensity bits
// - Modified: extremes use 4/2, else 5/1
// - Modified: 2-bit from memory, 1-bit fixed
// - Each component reduced to one bit
// - Modulation address is frame index over intensity[5:1]
// - Dither address is X, Y, intensity[3:0]
// - Mode bit: 0 normal, 1 modified
// - Random offsets added to frame index
package dfcr_pkg;

  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int unsigned INT_W      = 6;
  localparam int unsigned SEL_W      = 5;
  localparam int unsigned PHASE_W    = 2;
  localparam int unsigned FRAME_W    = 6;
  localparam int unsigned FRM_ADDR_W = FRAME_W + SEL_W;
  localparam int unsigned DTH_ADDR_W = 2 * PHASE_W + 4;
  localparam int unsigned FRM_DEPTH  = 1 << FRM_ADDR_W;
  localparam int unsigned DTH_DEPTH  = 1 << DTH_ADDR_W;
  localparam int unsigned NUM_COMP   = 3;

  // ---------------------------------------------------------------------------
  // Reset values and fixed codes
  // ---------------------------------------------------------------------------
  localparam logic [PHASE_W-1:0] PHASE_RST   = 2'h0;
  localparam logic [FRAME_W-1:0] FRAME_RST   = 6'h00;
  localparam logic [SEL_W-1:0]   SEL_MAX     = 5'h1F;
  localparam logic [3:0]         COARSE_MAX  = 4'hF;
  localparam logic [3:0]         COARSE_ZERO = 4'h0;
  localparam logic [1:0]         COMP_ALL    = 2'h0;
  localparam logic               MODE_NORMAL   = 1'b0;
  localparam logic               MODE_MODIFIED = 1'b1;

  // ---------------------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [INT_W-1:0] red;
    logic [INT_W-1:0] green;
    logic [INT_W-1:0] blue;
  } dfcr_rgb_type;

  typedef struct packed {
    logic [FRAME_W-1:0] red;
    logic [FRAME_W-1:0] green;
    logic [FRAME_W-1:0] blue;
  } dfcr_rand_type;

  typedef struct packed {
    logic                  wr;
    logic                  to_dither;
    logic [1:0]            comp;
    logic [FRM_ADDR_W-1:0] addr;
    logic                  data;
  } dfcr_memwr_type;

endpackage

// [dfcr_top_monitor.sv]
// Port checker of the dither and modulation colour path.
`timescale 1ns/1ps
`default_nettype none
module dfcr_top_monitor (
  // Clock, reset and stimulus
  input wire logic                           ref_clk_in,
  input wire logic                           rst_b_in,
  input wire logic                           pix_valid_in,
  input wire dfcr_pkg::dfcr_memwr_type       mem_wr_in,
  // Panel side
  input wire logic                           panel_valid_out,
  input wire logic [dfcr_pkg::NUM_COMP-1:0]  panel_bits_out
);
  // Sequence memory is cleared by reset, so every bit stays dark until it is loaded.
  logic seq_q;
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) seq_q <= 1'b0;
    else if (mem_wr_in.wr && !mem_wr_in.to_dither) seq_q <= 1'b1;
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  chk_valid_lat: assert property (pix_valid_in |=> panel_valid_out)
    else $error("valid pixel gave no panel strobe");
  chk_no_spur: assert property (!pix_valid_in |=> !panel_valid_out)
    else $error("panel strobe without pixel");
  chk_bits_hold: assert property (!pix_valid_in |=> $stable(panel_bits_out))
    else $error("panel bits moved without pixel");
  chk_bits_cause: assert property ($changed(panel_bits_out) |-> $past(pix_valid_in))
    else $error("panel bits changed with no pixel taken");
  chk_reset_quiet: assert property ($rose(rst_b_in) |->
    !panel_valid_out && panel_bits_out == 3'h0)
    else $error("outputs not cleared by reset");
  chk_run_pair: assert property (pix_valid_in ##1 pix_valid_in
    |=> panel_valid_out && $past(panel_valid_out))
    else $error("back to back pixels lost");
  chk_dark_empty: assert property (!seq_q |-> panel_bits_out == 3'h0)
    else $error("bit set with empty sequence memory");
  chk_valid_cause: assert property (panel_valid_out |-> $past(pix_valid_in))
    else $error("panel strobe has no source pixel");
  cover property (panel_valid_out && panel_bits_out != 3'h0);
  cover property (pix_valid_in ##1 pix_valid_in);
  cover property (seq_q && panel_valid_out && panel_bits_out == 3'h0);
endmodule
bind dfcr_top dfcr_top_monitor u_mon (
  .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .pix_valid_in(pix_valid_in),
  .mem_wr_in(mem_wr_in), .panel_valid_out(panel_valid_out), .panel_bits_out(panel_bits_out));
`default_nettype wire

// [dfcr_pix_src.sv]
// Behavioural pixel port source standing in for the graphics side.
`timescale 1ns/1ps
`default_nettype none
module dfcr_pix_src (
  // Clock
  input  wire logic                  ref_clk_in,
  // Pixel port
  output var logic                   pix_valid_out,
  output var dfcr_pkg::dfcr_rgb_type pix_rgb_out,
  output var logic                   line_done_out,
  output var logic                   frame_start_out
);
  initial begin
    pix_valid_out = 1'b0;
    pix_rgb_out = '0;
    line_done_out = 1'b0;
    frame_start_out = 1'b0;
  end
  // Data is inverted once released so a stale value never passes for a live one.
  task automatic send(input dfcr_pkg::dfcr_rgb_type v, input int n);
    @(posedge ref_clk_in);
    #1 pix_valid_out = 1'b1;
    pix_rgb_out = v;
    repeat (n) @(posedge ref_clk_in);
    #1 pix_valid_out = 1'b0;
    pix_rgb_out = ~v;
  endtask
  task automatic pulse(input logic fr);
    @(posedge ref_clk_in);
    #1 if (fr) frame_start_out = 1'b1; else line_done_out = 1'b1;
    @(posedge ref_clk_in);
    #1 frame_start_out = 1'b0;
    line_done_out = 1'b0;
  endtask
endmodule
`default_nettype wire

// [tb_dither_frm_color_reduction.sv]
// Self-checking testbench of the dither and modulation colour path.
`timescale 1ns/1ps
`default_nettype none
module tb_dither_frm_color_reduction;
  logic                     ref_clk_in = 1'b0;
  logic                     rst_b_in = 1'b0;
  logic                     mode = 1'b0;
  dfcr_pkg::dfcr_memwr_type mw = '0;
  dfcr_pkg::dfcr_rand_type  rp = '0;
  dfcr_pkg::dfcr_rand_type  rl = '0;
  dfcr_pkg::dfcr_rgb_type   rgb;
  logic                     pv, ld, fs, ov;
  logic [2:0]               ob;
  int                       n_errors = 0;
  int                       samples_checked = 0;
  always #50 ref_clk_in = ~ref_clk_in;
  dfcr_pix_src u_src (.ref_clk_in(ref_clk_in), .pix_valid_out(pv), .pix_rgb_out(rgb),
    .line_done_out(ld), .frame_start_out(fs));
  dfcr_top DUT (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .pix_valid_in(pv),
    .pix_rgb_in(rgb), .line_done_in(ld), .frame_start_in(fs), .rand_pixel_in(rp),
    .rand_line_in(rl), .mode_modified_in(mode), .mem_wr_in(mw),
    .panel_valid_out(ov), .panel_bits_out(ob));
  task automatic check(input logic [2:0] got, input logic [2:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic td, input logic [10:0] a, input logic d);
    @(posedge ref_clk_in);
    #1 mw = '{1'b1, td, 2'h0, a, d};
    @(posedge ref_clk_in);
    #1 mw = '0;
  endtask
  task automatic wseq(input logic [4:0] dv);
    for (int f = 0; f < 64; f++) wr(1'b0, {f[5:0], dv}, 1'b1);
  endtask
  task automatic px(input dfcr_pkg::dfcr_rgb_type v, input int n, input logic [2:0] e);
    u_src.send(v, n);
    check(ob, e);
    check({2'h0, ov}, 3'h1);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic t_offsets;
    rp = '{6'h02, 6'h00, 6'h00};
    rl = '{6'h03, 6'h00, 6'h00};
    wr(1'b0, {6'h05, 5'h03}, 1'b1);
    px('{6'h06, 6'h06, 6'h06}, 1, 3'h1);
    $display("offsets done");
  endtask
  task automatic t_split;
    wseq(5'h05);
    px('{6'h0A, 6'h0C, 6'h0B}, 2, 3'h5);
    $display("split done");
  endtask
  task automatic t_dither;
    u_src.pulse(1'b1);
    wr(1'b1, {3'h0, 8'h09}, 1'b1);
    px('{6'h09, 6'h09, 6'h09}, 1, 3'h7);
    px('{6'h09, 6'h09, 6'h09}, 1, 3'h0);
    wr(1'b1, {3'h0, 8'h09}, 1'b0);
    wr(1'b1, {3'h0, 8'h19}, 1'b1);
    u_src.pulse(1'b0);
    px('{6'h09, 6'h09, 6'h09}, 1, 3'h7);
    $display("dither done");
  endtask
  task automatic t_sat;
    u_src.pulse(1'b1);
    wr(1'b1, {3'h0, 8'h0F}, 1'b1);
    wseq(5'h1F);
    px('{6'h3F, 6'h3F, 6'h3F}, 1, 3'h7);
    $display("saturation done");
  endtask
  task automatic t_mod;
    mode = 1'b1;
    u_src.pulse(1'b1);
    wr(1'b1, {3'h0, 8'h01}, 1'b1);
    wseq(5'h02);
    wseq(5'h03);
    wseq(5'h09);
    px('{6'h01, 6'h01, 6'h01}, 1, 3'h7);
    px('{6'h11, 6'h11, 6'h11}, 1, 3'h7);
    mode = 1'b0;
    px('{6'h11, 6'h11, 6'h11}, 1, 3'h0);
    $display("modified done");
  endtask
  initial begin
    // Bound is several times the expected run of roughly seven hundred cycles.
    #500000;
    n_errors++;
    end_sim();
  end
  initial begin
    repeat (2) @(posedge ref_clk_in);
    #1 rst_b_in = 1'b1;
    check(ob, 3'h0);
    check({2'h0, ov}, 3'h0);
    t_offsets();
    t_split();
    t_dither();
    t_sat();
    t_mod();
    end_sim();
  end
endmodule
`default_nettype wire
